// ### logic/tcd_pkg.sv
// Purpose: shared constants for the trigger condition detector
// Assumes: one 200 MHz clock, AHB-Lite word registers
// Notes:   all offsets are byte addresses
package tcd_pkg;
  // sizes
  localparam int NUM_PINS  = 16;
  localparam int NUM_SYNC  = 7;
  localparam int NUM_CH    = 4;
  localparam int DATA_W    = 16;
  localparam int SEL_W     = 5;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_DSEL   = 8'h04;
  localparam logic [7:0] OFS_ASEL   = 8'h08;
  localparam logic [7:0] OFS_LEVEL  = 8'h0C;
  localparam logic [7:0] OFS_HYST   = 8'h10;
  localparam logic [7:0] OFS_WTOP   = 8'h14;
  localparam logic [7:0] OFS_WBOT   = 8'h18;
  localparam logic [7:0] OFS_SWTRIG = 8'h1C;
  localparam logic [7:0] OFS_STAT   = 8'h20;
  localparam logic [7:0] OFS_ISTAT  = 8'h24;
  localparam logic [7:0] OFS_IMASK  = 8'h28;
  // control field positions
  localparam int CB_EN   = 0;
  localparam int CB_ANA  = 1;
  localparam int CB_FALL = 2;
  localparam int CB_TYPE = 3;
  localparam int CB_EXIT = 6;
  localparam int CB_AI   = 7;
  localparam int CB_AO   = 8;
  localparam int CB_CTR  = 9;
  localparam int CTRL_W  = 10;
  // interrupt status bits
  localparam int IB_TRIG = 0;
  localparam int IB_RISE = 1;
  localparam int IB_FALL = 2;
  localparam int IRQ_W   = 3;
  // analog trigger types
  typedef enum logic [2:0] {
    TY_BELOW = 3'h0, TY_ABOVE = 3'h1, TY_HRISE = 3'h2,
    TY_HFALL = 3'h3, TY_WIN = 3'h4
  } tcd_atype_type;
  // detector states, gray along idle-armed-fired
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0, ST_ARMED = 2'h1, ST_FIRED = 2'h3
  } tcd_state_type;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage

// ### logic/tcd_dig_edge.sv
// Purpose: digital trigger source select and edge detect
// Assumes: pin and sync inputs synchronous to clk_sys
// Notes:   a select change masks one cycle to avoid false edges
`timescale 1ns/10ps
module tcd_dig_edge
  import tcd_pkg::*;
(
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst,
  // sources
  input  wire logic [NUM_PINS-1:0] pin_in,
  input  wire logic [NUM_SYNC-1:0] sync_in,
  // config
  input  wire logic [SEL_W-1:0]    src_sel,
  input  wire logic                fall_sel,
  // result
  output logic                     edge_evt,
  output logic                     src_lvl
);
  typedef struct packed {
    logic             prev;   // last sampled source
    logic [SEL_W-1:0] sel;    // select seen last cycle
    logic             evt;    // edge pulse
  } tcd_de_type;
  tcd_de_type st_ff, nxt_st;
  logic cur;                  // selected source level

  // source mux: msb picks sync bus, sync 7+ has no line
  always_comb begin
    cur = 1'b0;
    if (src_sel[SEL_W-1]) begin
      if (int'(src_sel[3:0]) < NUM_SYNC) begin
        cur = sync_in[src_sel[2:0]];
      end
    end else begin
      cur = pin_in[src_sel[3:0]];
    end
  end

  // edge detect, gated when the select just moved
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.prev = cur;
    nxt_st.sel  = src_sel;
    nxt_st.evt  = (src_sel == st_ff.sel) &&
                  (fall_sel ? (st_ff.prev && !cur)
                            : (!st_ff.prev && cur));
  end

  always_ff @(posedge clk_sys) begin
    if (rst) st_ff <= '0;
    else     st_ff <= nxt_st;
  end

  assign edge_evt = st_ff.evt;
  assign src_lvl  = st_ff.prev;
endmodule

// ### logic/tcd_ana_cmp.sv
// Purpose: analog channel select and threshold comparators
// Assumes: channel words are signed, already amplified
// Notes:   thresholds widened two bits so level+-hyst never wraps
`timescale 1ns/10ps
module tcd_ana_cmp
  import tcd_pkg::*;
(
  // clock and reset
  input  wire logic                           clk_sys,
  input  wire logic                           rst,
  // conditioned channels
  input  wire logic [NUM_CH-1:0][DATA_W-1:0]  ch_data,
  input  wire logic [1:0]                     ch_sel,
  // thresholds
  input  wire logic [DATA_W-1:0]              level,
  input  wire logic [DATA_W-1:0]              hyst,
  input  wire logic [DATA_W-1:0]              wtop,
  input  wire logic [DATA_W-1:0]              wbot,
  // registered flags
  output logic [7:0]                          flags
);
  typedef struct packed {
    logic [7:0] f;            // gt_bot lt_bot gt_top lt_top gt_lv lt_lv gt_hi lt_lo
  } tcd_ac_type;
  tcd_ac_type st_ff, nxt_st;
  // two guard bits: level plus a full-scale hysteresis still fits
  logic signed [DATA_W+1:0] v, lv, hi, lo, tp, bt;

  // widen signed, used for the channel, level, wtop and wbot; hyst is zero-extended
  function automatic logic signed [DATA_W+1:0] wid(
    input logic [DATA_W-1:0] x);
    wid = {{2{x[DATA_W-1]}}, x};
  endfunction

  // strict compares only, equal leaves flags clear
  always_comb begin
    v  = wid(ch_data[ch_sel]);
    lv = wid(level);
    hi = lv + {2'b00, hyst};
    lo = lv - {2'b00, hyst};
    tp = wid(wtop);
    bt = wid(wbot);
    nxt_st.f = {v > bt, v < bt, v > tp, v < tp,
                v > lv, v < lv, v > hi, v < lo};
  end

  always_ff @(posedge clk_sys) begin
    if (rst) st_ff <= '0;
    else     st_ff <= nxt_st;
  end

  assign flags = st_ff.f;
endmodule

// ### logic/tcd_top.sv
// Purpose: trigger condition detector with AHB-Lite registers
// Assumes: zero wait-state slave, word accesses only
// Notes:   comparator flags lag the channel value by one cycle
`timescale 1ns/10ps
module tcd_top
  import tcd_pkg::*;
(
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  // ahb-lite slave
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic                               hreadyout,
  output logic                               hresp,
  output logic [31:0]                        hrdata,
  // digital trigger terminals
  input  wire logic [NUM_PINS-1:0]           programmable_function_pin,
  input  wire logic [NUM_SYNC-1:0]           sync_bus_line,
  // conditioned analog channels
  input  wire logic [NUM_CH-1:0][DATA_W-1:0] ana_ch,
  // trigger consumers
  output logic                               trig_acq,
  output logic                               trig_gen,
  output logic                               trig_ctr,
  output logic                               ana_cmp_event,
  // interrupt
  output logic                               irq
);
  // all block state in one record
  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;   // control word
    logic [SEL_W-1:0]  dsel;   // digital source select
    logic [1:0]        asel;   // analog channel select
    logic [DATA_W-1:0] level;  // trigger level
    logic [DATA_W-1:0] hyst;   // hysteresis amount
    logic [DATA_W-1:0] wtop;   // window top
    logic [DATA_W-1:0] wbot;   // window bottom
    logic              sw;     // software trigger pulse
    tcd_state_type     fsm;    // hysteresis/window state
    logic              ace;    // comparison event level
    logic [IRQ_W-1:0]  istat;  // sticky events
    logic [IRQ_W-1:0]  imask;  // interrupt enables
    logic              irq;    // registered interrupt
    logic              t_acq;  // consumer pulses
    logic              t_gen;
    logic              t_ctr;
    logic              wr_pend; // write data phase due
    logic [7:0]        wr_ofs;  // its offset
    logic [31:0]       rdata;   // read data
  } tcd_regs_type;
  tcd_regs_type st_ff, nxt_st;

  // helper nets
  logic             dig_evt;   // digital edge pulse
  logic             dig_lvl;   // selected digital level
  logic [7:0]       fl;        // comparator flags
  logic             gt_bot, lt_bot, gt_top, lt_top;
  logic             gt_lv, lt_lv, gt_hi, lt_lo;
  logic             addr_ok;   // address phase accepted
  logic             arm_c;     // arm condition
  logic             fire_c;    // fire condition
  logic             ace_n;     // next comparison level
  logic             trig;      // combined trigger pulse
  logic [IRQ_W-1:0] ev;        // this cycle's events
  logic             reconf;    // config write this cycle
  tcd_atype_type    aty;       // analog trigger type

  // digital source and edge
  tcd_dig_edge u_dig (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .pin_in   (programmable_function_pin),
    .sync_in  (sync_bus_line),
    .src_sel  (st_ff.dsel),
    .fall_sel (st_ff.ctrl[CB_FALL]),
    .edge_evt (dig_evt),
    .src_lvl  (dig_lvl)
  );

  // analog comparators
  tcd_ana_cmp u_ana (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ch_data (ana_ch),
    .ch_sel  (st_ff.asel),
    .level   (st_ff.level),
    .hyst    (st_ff.hyst),
    .wtop    (st_ff.wtop),
    .wbot    (st_ff.wbot),
    .flags   (fl)
  );

  assign {gt_bot, lt_bot, gt_top, lt_top} = fl[7:4];
  assign {gt_lv, lt_lv, gt_hi, lt_lo}     = fl[3:0];
  assign aty = tcd_atype_type'(st_ff.ctrl[CB_TYPE +: 3]);

  // read mux, one decode shared by read path
  function automatic logic [31:0] rd_word(
    input tcd_regs_type s, input logic [7:0] a,
    input logic dl);
    rd_word = RST_WORD;
    case (a)
      OFS_CTRL:  rd_word[CTRL_W-1:0] = s.ctrl;
      OFS_DSEL:  rd_word[SEL_W-1:0]  = s.dsel;
      OFS_ASEL:  rd_word[1:0]        = s.asel;
      OFS_LEVEL: rd_word[DATA_W-1:0] = s.level;
      OFS_HYST:  rd_word[DATA_W-1:0] = s.hyst;
      OFS_WTOP:  rd_word[DATA_W-1:0] = s.wtop;
      OFS_WBOT:  rd_word[DATA_W-1:0] = s.wbot;
      OFS_STAT:  rd_word[3:0] = {dl, s.fsm, s.ace};
      OFS_ISTAT: rd_word[IRQ_W-1:0]  = s.istat;
      OFS_IMASK: rd_word[IRQ_W-1:0]  = s.imask;
      default:   rd_word = RST_WORD;
    endcase
  endfunction

  // address phase: any size is decoded; hsize only gates writes
  assign addr_ok = hsel && htrans[1] && hready;

  // arm and fire conditions per analog type
  always_comb begin
    arm_c  = 1'b0;
    fire_c = 1'b0;
    case (aty)
      TY_HRISE: begin
        arm_c  = lt_lo;
        fire_c = gt_lv;
      end
      TY_HFALL: begin
        arm_c  = gt_hi;
        fire_c = lt_lv;
      end
      TY_WIN: begin
        if (st_ff.ctrl[CB_EXIT]) begin
          arm_c  = gt_bot && lt_top;
          fire_c = lt_bot || gt_top;
        end else begin
          arm_c  = lt_bot || gt_top;
          fire_c = gt_bot && lt_top;
        end
      end
      default: begin
        arm_c  = 1'b0;
        fire_c = 1'b0;
      end
    endcase
  end

  // next-state logic for the whole block
  always_comb begin
    nxt_st = st_ff;
    reconf = 1'b0;
    ace_n  = 1'b0;
    trig   = 1'b0;
    ev     = '0;
    nxt_st.sw = 1'b0;

    // register write in data phase
    if (st_ff.wr_pend) begin
      case (st_ff.wr_ofs)
        OFS_CTRL: begin
          nxt_st.ctrl = hwdata[CTRL_W-1:0];
          reconf = 1'b1;
        end
        OFS_DSEL:  nxt_st.dsel = hwdata[SEL_W-1:0];
        OFS_ASEL: begin
          nxt_st.asel = hwdata[1:0];
          reconf = 1'b1;
        end
        OFS_LEVEL: begin
          nxt_st.level = hwdata[DATA_W-1:0];
          reconf = 1'b1;
        end
        OFS_HYST: begin
          nxt_st.hyst = hwdata[DATA_W-1:0];
          reconf = 1'b1;
        end
        OFS_WTOP: begin
          nxt_st.wtop = hwdata[DATA_W-1:0];
          reconf = 1'b1;
        end
        OFS_WBOT: begin
          nxt_st.wbot = hwdata[DATA_W-1:0];
          reconf = 1'b1;
        end
        OFS_SWTRIG: nxt_st.sw = hwdata[0];
        OFS_IMASK:  nxt_st.imask = hwdata[IRQ_W-1:0];
        default: begin
          // unmapped or read-only: write ignored
        end
      endcase
    end

    // hysteresis and window state machine
    case (st_ff.fsm)
      ST_IDLE:  if (arm_c)  nxt_st.fsm = ST_ARMED;
      ST_ARMED: if (fire_c) nxt_st.fsm = ST_FIRED;
      ST_FIRED: if (arm_c)  nxt_st.fsm = ST_ARMED;
      default:  nxt_st.fsm = ST_IDLE;
    endcase
    // reconfig or disabled detector drops back to idle
    if (reconf || !st_ff.ctrl[CB_EN]) begin
      nxt_st.fsm = ST_IDLE;
    end

    // comparison event level
    case (aty)
      TY_BELOW: ace_n = lt_lv;
      TY_ABOVE: ace_n = gt_lv;
      TY_HRISE, TY_HFALL, TY_WIN:
        ace_n = (nxt_st.fsm == ST_FIRED);
      default:  ace_n = 1'b0;
    endcase
    nxt_st.ace = ace_n && st_ff.ctrl[CB_EN] && !reconf;

    // combine sources; analog counts on its rising edge
    if (st_ff.ctrl[CB_EN]) begin
      if (st_ff.ctrl[CB_ANA]) begin
        trig = nxt_st.ace && !st_ff.ace;
      end else begin
        trig = dig_evt;
      end
    end
    trig = trig || st_ff.sw;

    // route to consumers as one-cycle pulses
    nxt_st.t_acq = trig && st_ff.ctrl[CB_AI];
    nxt_st.t_gen = trig && st_ff.ctrl[CB_AO];
    nxt_st.t_ctr = trig && st_ff.ctrl[CB_CTR];

    // sticky events; a set in the clear cycle wins
    ev[IB_TRIG] = trig;
    ev[IB_RISE] = nxt_st.ace && !st_ff.ace;
    ev[IB_FALL] = !nxt_st.ace && st_ff.ace;
    if (st_ff.wr_pend && st_ff.wr_ofs == OFS_ISTAT) begin
      nxt_st.istat = st_ff.istat & ~hwdata[IRQ_W-1:0];
    end
    nxt_st.istat = nxt_st.istat | ev;
    nxt_st.irq   = |(nxt_st.istat & nxt_st.imask);

    // capture address phase; read data ready next cycle
    nxt_st.wr_pend = addr_ok && hwrite && (hsize == 3'h2);
    nxt_st.wr_ofs  = haddr[7:0];
    if (addr_ok && !hwrite) begin
      nxt_st.rdata = (haddr[31:8] == 24'h00_0000)
                     ? rd_word(st_ff, haddr[7:0], dig_lvl)
                     : RST_WORD;
    end
    if (haddr[31:8] != 24'h00_0000) begin
      nxt_st.wr_pend = 1'b0;
    end
  end

  // single register stage for all state
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_ff     <= '0;
      st_ff.fsm <= ST_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs: bus handshake constant, the rest from flops
  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign hrdata        = st_ff.rdata;
  assign trig_acq      = st_ff.t_acq;
  assign trig_gen      = st_ff.t_gen;
  assign trig_ctr      = st_ff.t_ctr;
  assign ana_cmp_event = st_ff.ace;
  assign irq           = st_ff.irq;
endmodule

// ### test/tcd_src_model.sv
// Purpose: far-side model of trigger terminals and analog channels
// Assumes: levels change just after a rising clock edge
// Notes:   a level holds until the bench commands a new one
`timescale 1ns/10ps
module tcd_src_model
  import tcd_pkg::*;
(
  // clock
  input  wire logic                     clk_sys,
  // terminals and conditioned channels
  output logic [NUM_PINS-1:0]           pin_out,
  output logic [NUM_SYNC-1:0]           sync_out,
  output logic [NUM_CH-1:0][DATA_W-1:0] ch_out
);
  // quiet levels at time zero
  initial begin
    pin_out = '0;
    sync_out = '0;
    ch_out = '0;
  end
  // one terminal moves, launched off the edge
  task automatic set_line(input logic sy, input int i, input logic v);
    @(posedge clk_sys);
    if (sy) begin
      sync_out[i] <= v;
    end else begin
      pin_out[i] <= v;
    end
  endtask
  // one channel takes a new value
  task automatic set_ch(input int c, input logic [DATA_W-1:0] v);
    @(posedge clk_sys);
    ch_out[c] <= v;
  endtask
endmodule

// ### test/tcd_top_asserts.sv
// Purpose: port-level checks of the trigger condition detector
// Assumes: zero wait-state bus, causes seen within six edges
// Notes:   config is not visible here, so outputs are tied to causes
`timescale 1ns/10ps
module tcd_top_asserts
  import tcd_pkg::*;
(
  // clock and reset
  input wire logic                          clk_sys,
  input wire logic                          rst,
  // bus
  input wire logic                          hsel,
  input wire logic [31:0]                   haddr,
  input wire logic [1:0]                    htrans,
  input wire logic                          hwrite,
  input wire logic                          hready,
  input wire logic                          hreadyout,
  input wire logic                          hresp,
  input wire logic [31:0]                   hrdata,
  // sources
  input wire logic [NUM_PINS-1:0]           programmable_function_pin,
  input wire logic [NUM_SYNC-1:0]           sync_bus_line,
  input wire logic [NUM_CH-1:0][DATA_W-1:0] ana_ch,
  // results
  input wire logic                          trig_acq,
  input wire logic                          trig_gen,
  input wire logic                          trig_ctr,
  input wire logic                          ana_cmp_event,
  input wire logic                          irq
);
  logic       taken;      // request accepted at this edge
  logic [5:0] wr_ff;      // write history, bit 0 newest
  logic [5:0] cause_ff;   // any write or input change
  assign taken = hsel & htrans[1] & hready;
  // a deep window so exact pipeline depth does not matter
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_ff <= 6'h00;
      cause_ff <= 6'h00;
    end else begin
      wr_ff <= {wr_ff[4:0], taken & hwrite};
      cause_ff <= {cause_ff[4:0], (taken & hwrite)
        | $changed(programmable_function_pin)
        | $changed(sync_bus_line) | $changed(ana_ch)};
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // a read address phase accepted
  sequence rd_s;
    taken && !hwrite;
  endsequence
  ready_high_a: assert property (hreadyout)
    else $error("slave stalled the bus");
  resp_okay_a: assert property (!hresp)
    else $error("slave answered with an error");
  unmapped_zero_a: assert property (rd_s ##0
    (haddr[7:2] > OFS_IMASK[7:2]) |=> hrdata == 32'h0000_0000)
    else $error("unmapped read gave data");
  rdata_hold_a: assert property ($changed(hrdata) |-> $past(taken && !hwrite))
    else $error("read data moved without a read");
  trig_pulse_a: assert property ((trig_acq ##1 trig_acq) |->
    (|cause_ff[3:0])) else $error("trigger held without cause");
  trig_cause_a: assert property ($rose(trig_acq | trig_gen | trig_ctr)
    |-> (|cause_ff)) else $error("trigger without any cause");
  event_cause_a: assert property ($changed(ana_cmp_event)
    |-> (|cause_ff)) else $error("comparison event moved alone");
  irq_drop_a: assert property ($fell(irq) |-> (|wr_ff))
    else $error("interrupt dropped without a write");
  irq_rise_a: assert property ($rose(irq) |-> (|cause_ff))
    else $error("interrupt rose without cause");
endmodule
bind tcd_top tcd_top_asserts chk_i (.clk_sys(clk_sys), .rst(rst),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .programmable_function_pin(programmable_function_pin),
  .sync_bus_line(sync_bus_line), .ana_ch(ana_ch), .trig_acq(trig_acq),
  .trig_gen(trig_gen), .trig_ctr(trig_ctr),
  .ana_cmp_event(ana_cmp_event), .irq(irq));

// ### test/trigger_condition_detect_bench.sv
// Purpose: self-checking bench for the trigger condition detector
// Assumes: zero wait-state slave, analog channel 2 used for tests
// Notes:   trigger pulses are counted by a monitor, not sampled
`timescale 1ns/10ps
module trigger_condition_detect_bench
  import tcd_pkg::*;
;
  logic clk_sys, rst, hsel, hwrite, hreadyout, hresp;  // bus
  logic [31:0] haddr, hwdata, hrdata, rd;              // bus words
  logic [1:0] htrans;                                  // transfer kind
  logic [2:0] hsize;                                   // always word
  logic [NUM_PINS-1:0] pins;                           // pin levels
  logic [NUM_SYNC-1:0] sync;                           // sync levels
  logic [NUM_CH-1:0][DATA_W-1:0] ana;                  // channels
  logic trig_acq, trig_gen, trig_ctr, ace, irq;        // results
  int errors, compares, n_a, n_g, n_c, a0, g0, c0;     // tallies
  tcd_top uut (.clk_sys(clk_sys), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .programmable_function_pin(pins),
    .sync_bus_line(sync), .ana_ch(ana), .trig_acq(trig_acq),
    .trig_gen(trig_gen), .trig_ctr(trig_ctr), .ana_cmp_event(ace),
    .irq(irq));
  tcd_src_model src (.clk_sys(clk_sys), .pin_out(pins),
    .sync_out(sync), .ch_out(ana));
  // 200 MHz clock
  always #2.5 clk_sys = ~clk_sys;
  // pulse monitor, pre-edge values
  always @(posedge clk_sys) begin
    if (trig_acq === 1'b1) n_a++;
    if (trig_gen === 1'b1) n_g++;
    if (trig_ctr === 1'b1) n_c++;
  end
  task automatic report_and_stop();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string m);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t %s got %h", $time, m, got);
    end
  endtask
  // wait for hready at an edge, bounded
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        errors++;
        report_and_stop();
      end
      @(posedge clk_sys);
    end
  endtask
  // one single word transfer, data taken at the data-phase edge
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    chk(32'(hresp), 32'h0, "response not okay");
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, 32'(a), d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, 32'(a), 32'h0);
    chk(rd, e, "register read");
  endtask
  // control word, all consumers on
  function automatic logic [31:0] ctl(input logic f, input logic [2:0] t,
    input logic x);
    ctl = 32'h0000_0383;
    ctl[CB_FALL] = f;
    ctl[CB_TYPE+:3] = t;
    ctl[CB_EXIT] = x;
  endfunction
  // pulse counts packed: acq, gen<<4, ctr<<8
  task automatic pulses(input logic [31:0] e, input string m);
    repeat (6) @(posedge clk_sys);
    chk(32'(n_a - a0 + 16 * (n_g - g0) + 256 * (n_c - c0)), e, m);
  endtask
  task automatic snap();
    a0 = n_a;
    g0 = n_g;
    c0 = n_c;
  endtask
  // channel 2 value, then the settled event level
  task automatic av(input logic [15:0] v, input logic e);
    src.set_ch(2, v);
    repeat (5) @(posedge clk_sys);
    chk(32'(ace), 32'(e), "comparison event");
  endtask
  task automatic t_regs();
    rd_chk(OFS_CTRL, 32'h0);
    rd_chk(OFS_ISTAT, 32'h0);
    wr(OFS_LEVEL, 32'h0000_1234);
    rd_chk(OFS_LEVEL, 32'h0000_1234);
    wr(8'h40, 32'hFFFF_FFFF);
    rd_chk(8'h40, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_digital();
    logic [3:0] sy, fl;
    int ix [4];
    sy = 4'b1100;
    fl = 4'b1010;
    ix = '{3, 15, 0, 6};
    for (int k = 0; k < 4; k++) begin
      src.set_line(sy[k], ix[k], fl[k]);
      wr(OFS_DSEL, 32'(ix[k]) | (sy[k] ? 32'h10 : 32'h0));
      // digital source: the analog select bit must be off here
      wr(OFS_CTRL, ctl(fl[k], 3'h0, 1'b0) & ~(32'h1 << CB_ANA));
      snap();
      src.set_line(sy[k], ix[k], ~fl[k]);
      pulses(32'h111, "chosen edge");
      snap();
      src.set_line(sy[k], ix[k], fl[k]);
      pulses(32'h0, "opposite edge");
    end
    $display("test digital done");
  endtask
  task automatic t_soft();
    for (int i = 0; i < 3; i++) begin
      wr(OFS_CTRL, 32'h1 << (CB_AI + i));
      snap();
      wr(OFS_SWTRIG, 32'h1);
      pulses(32'h1 << (4 * i), "software trigger");
    end
    $display("test soft done");
  endtask
  task automatic t_level();
    src.set_ch(1, 16'h7000);
    wr(OFS_ASEL, 32'h2);
    wr(OFS_LEVEL, 32'h0064);
    wr(OFS_CTRL, ctl(1'b0, TY_BELOW, 1'b0));
    av(16'h0032, 1'b1);
    av(16'h0064, 1'b0);
    wr(OFS_CTRL, ctl(1'b0, TY_ABOVE, 1'b0));
    av(16'h0064, 1'b0);
    snap();
    av(16'h0096, 1'b1);
    pulses(32'h111, "analog trigger");
    $display("test level done");
  endtask
  task automatic t_hyst();
    wr(OFS_HYST, 32'h0014);
    src.set_ch(2, 16'h0078);
    wr(OFS_CTRL, ctl(1'b0, TY_HRISE, 1'b0));
    av(16'h0078, 1'b0);
    av(16'h0050, 1'b0);
    av(16'h0046, 1'b0);
    av(16'h0064, 1'b0);
    av(16'h0065, 1'b1);
    av(16'h0050, 1'b1);
    // sync line 6 is still selected and high: level bit set
    rd_chk(OFS_STAT, 32'h0000_000F);
    wr(OFS_LEVEL, 32'h0064);
    av(16'h0065, 1'b0);
    wr(OFS_CTRL, ctl(1'b0, TY_HFALL, 1'b0));
    av(16'h0063, 1'b0);
    av(16'h0078, 1'b0);
    av(16'h0079, 1'b0);
    av(16'h0064, 1'b0);
    av(16'h0063, 1'b1);
    av(16'h0078, 1'b1);
    av(16'h0079, 1'b0);
    $display("test hyst done");
  endtask
  task automatic t_window();
    wr(OFS_WTOP, 32'h00C8);
    wr(OFS_WBOT, 32'h0064);
    src.set_ch(2, 16'h0032);
    wr(OFS_CTRL, ctl(1'b0, TY_WIN, 1'b0));
    av(16'h0064, 1'b0);
    av(16'h0096, 1'b1);
    wr(OFS_CTRL, ctl(1'b0, TY_WIN, 1'b1));
    av(16'h0096, 1'b0);
    av(16'h00C8, 1'b0);
    av(16'h00C9, 1'b1);
    av(16'h0096, 1'b0);
    rd_chk(OFS_STAT, 32'h0000_000A);
    // mid-run reset must drop the armed state and all config
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd_chk(OFS_STAT, 32'h0);
    $display("test window done");
  endtask
  task automatic t_irq();
    wr(OFS_CTRL, 32'h0000_0380);
    wr(OFS_ISTAT, 32'h7);
    wr(OFS_SWTRIG, 32'h1);
    rd_chk(OFS_ISTAT, 32'h1);
    chk(32'(irq), 32'h0, "masked interrupt");
    wr(OFS_IMASK, 32'h1);
    repeat (3) @(posedge clk_sys);
    chk(32'(irq), 32'h1, "unmasked interrupt");
    wr(OFS_ISTAT, 32'h1);
    repeat (3) @(posedge clk_sys);
    chk(32'(irq), 32'h0, "cleared interrupt");
    rd_chk(OFS_ISTAT, 32'h0);
    $display("test irq done");
  endtask
  // hang guard
  initial begin
    repeat (40000) @(posedge clk_sys);
    errors++;
    report_and_stop();
  end
  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_digital();
    t_soft();
    t_level();
    t_hyst();
    t_window();
    t_irq();
    report_and_stop();
  end
endmodule
